// File: hdl/bdm_regfile.sv
/*
 Banked data memory with pointer-based indirect access: special
 function register storage, shared and per-bank general purpose bytes.
 Assumes one core request per cycle on the core clock; peripherals read
 their special function bytes from spec_file_out.
*/
`timescale 1ns/1ns
`include "bdm_cfg.svh"
// Function
// - Sixteen special function registers and 67 general bytes in one space.
// - General bytes reachable by direct offset and through the pointer.
// - Indirect port has no storage; accesses go to the pointed location.
// - Reading the indirect port through itself returns 00h.
// - Writing the indirect port through itself stores nothing.
// - Pointer is eight bits and addresses every indirect access.
// - Pointer bits four to zero pick offsets 00h to 1Fh.
// - Pointer bits six and five pick banks zero to three.
// - Pointer bit seven ignores writes and always reads one.
module bdm_regfile
   import bdm_pkg::*;
#(
   parameter int BANKS      = `BDM_BANK_COUNT,
   parameter int BANK_BYTES = `BDM_BANKED_COUNT,
   parameter int SHARED     = `BDM_SHARED_COUNT
)
(
   input  wire logic      clk_in,
   input  wire logic      sys_rst_in,
   input  wire bdm_req_s  core_req_in,
   output bdm_resp_s      core_resp_out,
   output logic [7:0]     pointer_out,
   output bdm_spec_t      spec_file_out
);
   localparam int BANKED = BANKS * BANK_BYTES;
   localparam int BW     = $clog2(BANKED);

   logic [6:0]   ptr_q;
   logic [6:0]   ptr_d;
   logic [7:0]   spec_q   [`BDM_SPEC_COUNT];
   logic [7:0]   spec_d   [`BDM_SPEC_COUNT];
   logic [7:0]   shared_q [SHARED];
   logic [7:0]   shared_d [SHARED];
   logic [7:0]   banked_q [BANKED];
   logic [7:0]   banked_d [BANKED];
   bdm_resp_s    resp_q;
   bdm_resp_s    resp_d;
   logic [6:0]   eff;
   logic [4:0]   off;
   logic [1:0]   bank;
   bdm_region_e  region;
   logic [3:0]   spec_idx;
   logic [1:0]   shared_idx;
   logic [BW-1:0] banked_idx;
   logic         ptr_we;
   logic         spec_we;
   logic         shared_we;
   logic         banked_we;
   logic [7:0]   rdata;
   logic [8:0]   key;

   // ---------------------------------------------------------------
   // Address resolution
   // ---------------------------------------------------------------
   always_comb
   begin
      if (core_req_in.addr == `BDM_OFF_INDIRECT)
      begin
         eff = ptr_q;
      end
      else
      begin
         eff = {ptr_q[`BDM_PTR_BANK_MSB:`BDM_PTR_BANK_LSB],
                core_req_in.addr};
      end
      off  = eff[`BDM_PTR_OFF_MSB:0];
      bank = eff[`BDM_PTR_BANK_MSB:`BDM_PTR_BANK_LSB];
   end

   always_comb
   begin
      spec_idx   = off[3:0];
      shared_idx = 2'(off - `BDM_OFF_SHARED_LO);
      banked_idx = BW'({bank, off[3:0]});
      if (off == `BDM_OFF_INDIRECT)
      begin
         region = BDM_SELF;
      end
      else if (off == `BDM_OFF_POINTER)
      begin
         region = BDM_PTR;
      end
      else if (off <= `BDM_OFF_SPEC_LAST)
      begin
         region = BDM_SPEC;
         if (bank[0] && off == `BDM_OFF_ALT_A)
         begin
            spec_idx = `BDM_IDX_ALT_A;
         end
         else if (bank[0] && off == `BDM_OFF_ALT_B)
         begin
            spec_idx = `BDM_IDX_ALT_B;
         end
         else if (bank[0] && off == `BDM_OFF_ALT_C)
         begin
            spec_idx = `BDM_IDX_ALT_C;
         end
      end
      else if (off <= `BDM_OFF_SHARED_HI)
      begin
         region = BDM_SHARED;
      end
      else
      begin
         region = BDM_BANKED;
      end
   end

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   always_comb
   begin
      ptr_we    = core_req_in.wr && region == BDM_PTR;
      spec_we   = core_req_in.wr && region == BDM_SPEC;
      shared_we = core_req_in.wr && region == BDM_SHARED;
      banked_we = core_req_in.wr && region == BDM_BANKED;
      ptr_d     = ptr_q;
      if (ptr_we)
      begin
         ptr_d = core_req_in.wdata[6:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < BANKED; g++)
      begin : g_banked
         assign banked_d[g] = (banked_we && banked_idx == BW'(g)) ?
                              core_req_in.wdata : banked_q[g];
      end
      for (g = 0; g < SHARED; g++)
      begin : g_shared
         assign shared_d[g] = (shared_we && shared_idx == 2'(g)) ?
                              core_req_in.wdata : shared_q[g];
      end
      for (g = 0; g < `BDM_SPEC_COUNT; g++)
      begin : g_spec
         assign spec_d[g] = (spec_we && spec_idx == 4'(g)) ?
                            core_req_in.wdata : spec_q[g];
         if (g == 0)
         begin : g_self
            assign spec_file_out[g] = `BDM_SELF_READ;
         end
         else if (g == 4)
         begin : g_ptr
            assign spec_file_out[g] = pointer_out;
         end
         else
         begin : g_reg
            assign spec_file_out[g] = spec_q[g];
         end
      end
   endgenerate

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         ptr_q    <= `BDM_PTR_RST;
         spec_q   <= '{default: `BDM_BYTE_RST};
         shared_q <= '{default: `BDM_BYTE_RST};
         banked_q <= '{default: `BDM_BYTE_RST};
      end
      else
      begin
         ptr_q    <= ptr_d;
         spec_q   <= spec_d;
         shared_q <= shared_d;
         banked_q <= banked_d;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   always_comb
   begin
      case (region)
         BDM_SELF:   rdata = `BDM_SELF_READ;
         BDM_PTR:    rdata = {`BDM_PTR_TOP_READ, ptr_q};
         BDM_SPEC:   rdata = spec_q[spec_idx];
         BDM_SHARED: rdata = shared_q[shared_idx];
         default:    rdata = banked_q[banked_idx];
      endcase
      resp_d.valid = core_req_in.rd;
      resp_d.data  = core_req_in.rd ? rdata : resp_q.data;
   end

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         resp_q <= '0;
      end
      else
      begin
         resp_q <= resp_d;
      end
   end

   assign core_resp_out = resp_q;
   assign pointer_out   = {`BDM_PTR_TOP_READ, ptr_q};

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [8:0] lw_key_q;
   logic [7:0] lw_data_q;
   logic       lw_ok_q;

   always_comb
   begin
      if (region == BDM_SPEC)
      begin
         key = {5'h10, spec_idx};
      end
      else if (region == BDM_SHARED)
      begin
         key = {4'h0, off};
      end
      else
      begin
         key = {2'h0, eff};
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         lw_key_q  <= '0;
         lw_data_q <= '0;
         lw_ok_q   <= 1'b0;
      end
      else if (spec_we || shared_we || banked_we)
      begin
         lw_key_q  <= key;
         lw_data_q <= core_req_in.wdata;
         lw_ok_q   <= 1'b1;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   property p_spec_write;
      spec_we |=> spec_file_out[$past(spec_idx)] == $past(core_req_in.wdata);
   endproperty
   a_spec_write: assert property (p_spec_write)
      else $error("special byte write not stored");
   property p_gp_hold;
      core_req_in.rd && region == BDM_BANKED && lw_ok_q &&
      !core_req_in.wr && key == lw_key_q
      |=> core_resp_out.data == $past(lw_data_q);
   endproperty
   a_gp_hold: assert property (p_gp_hold)
      else $error("general byte lost its value");
   property p_indirect;
      core_req_in.rd && !core_req_in.wr && lw_ok_q &&
      core_req_in.addr == `BDM_OFF_INDIRECT &&
      region != BDM_SELF && region != BDM_PTR && key == lw_key_q
      |=> core_resp_out.valid && core_resp_out.data == $past(lw_data_q);
   endproperty
   a_indirect: assert property (p_indirect)
      else $error("indirect read missed the pointed byte");
   property p_self_read;
      core_req_in.rd && region == BDM_SELF
      |=> core_resp_out.valid && core_resp_out.data == 8'h00;
   endproperty
   a_self_read: assert property (p_self_read)
      else $error("self read not zero");
   property p_self_write;
      core_req_in.wr && region == BDM_SELF
      |=> $stable(lw_key_q) && $stable(lw_data_q) && $stable(ptr_q);
   endproperty
   a_self_write: assert property (p_self_write)
      else $error("self write stored data");
   property p_ptr_write;
      core_req_in.wr && region == BDM_PTR
      |=> pointer_out == {1'b1, $past(core_req_in.wdata[6:0])};
   endproperty
   a_ptr_write: assert property (p_ptr_write)
      else $error("pointer write wrong");
   property p_offset;
      core_req_in.addr == `BDM_OFF_INDIRECT
      |-> off == pointer_out[4:0] && bank == pointer_out[6:5];
   endproperty
   a_offset: assert property (p_offset)
      else $error("indirect offset not from pointer");
   property p_bank;
      region == BDM_BANKED
      |-> banked_idx == BW'({pointer_out[6:5], off[3:0]});
   endproperty
   a_bank: assert property (p_bank)
      else $error("bank select wrong");
   property p_top_bit;
      pointer_out[7] && core_resp_out.data[7] ||
      !$past(core_req_in.rd && region == BDM_PTR);
   endproperty
   a_top_bit: assert property (p_top_bit)
      else $error("pointer bit seven not one");
   property p_alt;
      region == BDM_SPEC && bank[0] && off == `BDM_OFF_ALT_B
      |-> spec_idx == `BDM_IDX_ALT_B;
   endproperty
   a_alt: assert property (p_alt)
      else $error("alternate register not selected");
   property p_shared;
      core_req_in.rd && !core_req_in.wr && region == BDM_SHARED &&
      lw_ok_q && key == lw_key_q
      |=> core_resp_out.data == $past(lw_data_q);
   endproperty
   a_shared: assert property (p_shared)
      else $error("shared byte differs between banks");
   c_indirect: cover property (core_req_in.rd &&
      core_req_in.addr == `BDM_OFF_INDIRECT && region == BDM_BANKED);
   c_self: cover property (core_req_in.rd && region == BDM_SELF);
   c_bank3: cover property (core_req_in.wr && bank == 2'h3 &&
      region == BDM_BANKED);
   c_alias: cover property (core_req_in.rd && region == BDM_SHARED &&
      bank != 2'h0 && key == lw_key_q && lw_ok_q);
endmodule : bdm_regfile

// File: shared/bdm_cfg.svh
/*
 Offsets, field positions, reset values and sizes of the banked data
 memory. Assumes inclusion by the package and the register file.
*/
`ifndef BDM_CFG_SVH
`define BDM_CFG_SVH
`define BDM_OFF_INDIRECT   5'h00
`define BDM_OFF_POINTER    5'h04
`define BDM_OFF_ALT_A      5'h01
`define BDM_OFF_ALT_B      5'h05
`define BDM_OFF_ALT_C      5'h06
`define BDM_OFF_SPEC_LAST  5'h0C
`define BDM_OFF_SHARED_LO  5'h0D
`define BDM_OFF_SHARED_HI  5'h0F
`define BDM_OFF_BANKED_LO  5'h10
`define BDM_IDX_ALT_A      4'hD
`define BDM_IDX_ALT_B      4'hE
`define BDM_IDX_ALT_C      4'hF
`define BDM_PTR_OFF_MSB    4
`define BDM_PTR_BANK_MSB   6
`define BDM_PTR_BANK_LSB   5
`define BDM_PTR_RST        7'h00
`define BDM_PTR_TOP_READ   1'h1
`define BDM_SELF_READ      8'h00
`define BDM_BYTE_RST       8'h00
`define BDM_SPEC_COUNT     16
`define BDM_SHARED_COUNT   3
`define BDM_BANKED_COUNT   16
`define BDM_BANK_COUNT     4
`endif

// File: shared/bdm_pkg.sv
/*
 Types of the banked data memory. Assumes bdm_cfg.svh is on the
 include path.
*/
package bdm_pkg;
`include "bdm_cfg.svh"
   typedef enum logic [2:0]
   {
      BDM_SELF,
      BDM_PTR,
      BDM_SPEC,
      BDM_SHARED,
      BDM_BANKED
   } bdm_region_e;

   typedef struct packed
   {
      logic       rd;
      logic       wr;
      logic [4:0] addr;
      logic [7:0] wdata;
   } bdm_req_s;

   typedef struct packed
   {
      logic       valid;
      logic [7:0] data;
   } bdm_resp_s;

   typedef logic [`BDM_SPEC_COUNT-1:0][7:0] bdm_spec_t;
endpackage : bdm_pkg

// File: tb/bdm_core_model.sv
/*
 Core datapath model: issues one data memory access per cycle.
 Assumes the caller starts each access at a falling clock edge.
*/
`timescale 1ns/1ns
module bdm_core_model
   import bdm_pkg::*;
(
   input  wire logic      clk_in,
   input  wire bdm_resp_s resp_in,
   output bdm_req_s       req_out
);
   // ------------------------------
   // Access
   // ------------------------------
   initial
   begin
      req_out = '0;
   end

   // Drives a request, holds it over one rising edge, takes the answer.
   task automatic access(input  logic       rd,
                         input  logic       wr,
                         input  logic [4:0] addr,
                         input  logic [7:0] wdata,
                         output bdm_resp_s  resp);
      req_out = '{rd, wr, addr, wr ? wdata : ~req_out.wdata};
      @(posedge clk_in);
      @(negedge clk_in);
      resp = resp_in;
   endtask : access

   // Releases the request; released data shows the inverse value.
   task automatic idle();
      req_out = '{1'b0, 1'b0, req_out.addr, ~req_out.wdata};
      @(negedge clk_in);
   endtask : idle
endmodule : bdm_core_model

// File: tb/testbench.sv
/*
 Self-checking bench of the banked data memory with a reference model.
 Assumes the design and the core model are compiled before it.
*/
`timescale 1ns/1ns
module testbench
   import bdm_pkg::*;
;
   logic       clk_in;
   logic       sys_rst_in;
   bdm_req_s   req;
   bdm_resp_s  resp;
   logic [7:0] pointer_w;
   bdm_spec_t  spec;
   int         n_fail;
   int         total_checks;
   int         seed;
   int         r;
   logic [7:0] mem [256];
   logic [6:0] eptr;

   bdm_regfile bdm_regfile_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .core_req_in(req), .core_resp_out(resp), .pointer_out(pointer_w),
      .spec_file_out(spec));
   bdm_core_model bdm_core_model_i (.clk_in(clk_in), .resp_in(resp),
      .req_out(req));

   // ------------------------------
   // Reference model
   // ------------------------------
   // Maps bank and offset to one physical byte key.
   function automatic logic [7:0] key(input logic [1:0] b,
                                      input logic [4:0] o);
      if (o >= 5'h10)
         return {1'b0, b, o};
      if (o >= 5'h0D)
         return {3'h0, o};
      if (b[0] && (o == 5'h01))
         return 8'h8D;
      if (b[0] && (o == 5'h05))
         return 8'h8E;
      if (b[0] && (o == 5'h06))
         return 8'h8F;
      return {4'h8, o[3:0]};
   endfunction : key

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Performs one access and compares the answer with the model.
   task automatic op(input logic rd, input logic wr,
                     input logic [4:0] a, input logic [7:0] wd);
      bdm_resp_s  rs;
      logic [4:0] o;
      logic [7:0] k;
      logic [7:0] ex;
      o = (a == 5'h00) ? eptr[4:0] : a;
      k = key(eptr[6:5], o);
      ex = (o == 5'h00) ? 8'h00 : (o == 5'h04) ? {1'b1, eptr} : mem[k];
      if (wr && (o == 5'h04))
         eptr = wd[6:0];
      else if (wr && (o != 5'h00))
         mem[k] = wd;
      bdm_core_model_i.access(rd, wr, a, wd, rs);
      check({7'h00, rs.valid}, {7'h00, rd});
      if (rd)
         check(rs.data, ex);
      check(pointer_w, {1'b1, eptr});
   endtask : op

   task automatic check_spec();
      logic [7:0] e;
      for (int i = 0; i < 16; i++)
      begin
         e = (i == 0) ? 8'h00 : mem[{4'h8, i[3:0]}];
         if (i == 4)
            e = {1'b1, eptr};
         check(spec[i], e);
      end
   endtask : check_spec

   task automatic complete_run();
      if ((n_fail == 0) && (total_checks > 0))
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   // ------------------------------
   // Stimulus
   // ------------------------------
   always #20 clk_in = ~clk_in;

   initial
   begin
      clk_in = 1'b0;
      sys_rst_in = 1'b1;
      seed = 69;
      n_fail = 0;
      total_checks = 0;
      eptr = 7'h00;
      for (int i = 0; i < 256; i++)
         mem[i] = 8'h00;
      repeat (4) @(negedge clk_in);
      sys_rst_in = 1'b0;
      check(pointer_w, 8'h80);
      check_spec();
      op(1'b1, 1'b1, 5'h04, 8'hFF);
      op(1'b1, 1'b1, 5'h00, 8'h5A);
      op(1'b0, 1'b1, 5'h04, 8'h00);
      op(1'b1, 1'b1, 5'h00, 8'hA5);
      op(1'b1, 1'b0, 5'h00, 8'h00);
      for (int b = 0; b < 4; b++)
      begin
         op(1'b0, 1'b1, 5'h04, {1'b0, b[1:0], 5'h00});
         foreach (mem[i])
            if (i inside {1, 5, 6, 13, 15, 16, 31})
               op(1'b1, 1'b1, i[4:0], {1'b1, b[1:0], i[4:0]});
      end
      repeat (600)
      begin
         r = $random(seed);
         op(r[0], r[1], r[6:2], r[14:7]);
      end
      check_spec();
      bdm_core_model_i.idle();
      complete_run();
   end

   initial
   begin
      #(40 * 5000);
      n_fail++;
      complete_run();
   end
endmodule : testbench
